//--- rtl/fdoc_config.sv
// Purpose: Floppy drive option configuration register and rate pin control
// Assumes: rstn_i is the power-up reset; config_mode_i comes from entry logic
// Notes:   Selector and data strobes are single-cycle, same clock domain
//
// Behaviour
// - Bit 0 ignores writes, reads zero
// - Bit 1 selects normal or enhanced mode
// - Bits 3,4 are rate-pin option, default 11
// - Enhanced mode makes option bits don't-care
// - Option 00: pins follow rate select
// - Option 01: remapped pin encoding per rate
// - Option 11: rate pins become inputs
// - Code 01 means 300 or 500 kb/s
// - Bits 6,5 select host interface mode
// - Bits 7,2 select shared pin function
// - Index 04 register, config mode, resets 00
// - Index 03 register, config mode, resets 78
// - Only power-up reset loads defaults
`include "fdoc_regs.svh"
`default_nettype none

module fdoc_config (
    input  wire logic                     clk_i,
    input  wire logic                     rstn_i,
    input  wire logic                     config_mode_i,
    input  wire logic                     sel_wr_i,
    input  wire logic                     data_wr_i,
    input  wire logic                     data_rd_i,
    input  wire logic [7:0]               wdata_i,
    output logic      [7:0]               rdata_o,
    input  wire logic [1:0]               rate_select_field_i,
    input  wire logic                     alt_rate_300_i,
    output fdoc_pkg::fdoc_rate_type       xfer_rate_o,
    output logic                          rate_pin_high_o,
    output logic                          rate_pin_high_oe_n_o,
    input  wire logic                     rate_pin_high_i,
    output logic                          rate_pin_low_o,
    output logic                          rate_pin_low_oe_n_o,
    input  wire logic                     rate_pin_low_i,
    output logic      [1:0]               rate_pins_in_o,
    output logic                          enhanced_floppy_mode_two_o,
    output fdoc_pkg::fdoc_host_mode_type  host_mode_o,
    output fdoc_pkg::fdoc_share_type      shared_pin_func_o,
    output logic      [7:0]               port_extended_setup_o
);
    import fdoc_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]    config_selector;
        logic [7:0]    floppy_drive_option_config;
        logic [7:0]    port_extended_setup;
        logic [7:0]    rdata;
        logic [1:0]    pin_sync1;
        logic [1:0]    pin_sync2;
        fdoc_rate_type xfer_rate;
    } fdoc_state_type;

    fdoc_state_type st;
    fdoc_state_type next_st;
    fdoc_map_if     map_bus ();

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic fdoc_rate_type rate_of(input logic [1:0] sel, input logic alt300);
        case (sel)
            2'h3:    rate_of = rate_1000;
            2'h0:    rate_of = rate_500;
            2'h2:    rate_of = rate_250;
            default: rate_of = alt300 ? rate_300 : rate_500;
        endcase
    endfunction

    function automatic logic [7:0] fdo_store(input logic [7:0] d);
        fdo_store                = d;
        fdo_store[`FDOC_BIT_RSV] = 1'b0;
    endfunction

    // ------------------------------------------------------------------------
    // Register access and pin sampling
    // ------------------------------------------------------------------------
    always_comb begin
        next_st           = st;
        next_st.pin_sync1 = {rate_pin_high_i, rate_pin_low_i};
        next_st.pin_sync2 = st.pin_sync1;
        next_st.xfer_rate = rate_of(rate_select_field_i, alt_rate_300_i);
        next_st.rdata     = `FDOC_RD_IDLE;
        if (config_mode_i) begin
            if (data_wr_i && st.config_selector == `FDOC_IDX_FDO) begin
                next_st.floppy_drive_option_config = fdo_store(wdata_i);
            end else if (data_wr_i && st.config_selector == `FDOC_IDX_PES) begin
                next_st.port_extended_setup = wdata_i;
            end
            if (data_rd_i && st.config_selector == `FDOC_IDX_FDO) begin
                next_st.rdata = fdo_store(st.floppy_drive_option_config);
            end else if (data_rd_i && st.config_selector == `FDOC_IDX_PES) begin
                next_st.rdata = st.port_extended_setup;
            end
            if (sel_wr_i) begin
                next_st.config_selector = wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st.config_selector            <= `FDOC_SEL_RST;
            st.floppy_drive_option_config <= `FDOC_FDO_RST;
            st.port_extended_setup        <= `FDOC_PES_RST;
            st.rdata                      <= `FDOC_RD_IDLE;
            st.pin_sync1                  <= 2'h0;
            st.pin_sync2                  <= 2'h0;
            st.xfer_rate                  <= rate_500;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------------
    // Rate pin mapper
    // ------------------------------------------------------------------------
    assign map_bus.enhanced = st.floppy_drive_option_config[`FDOC_BIT_ENH];
    assign map_bus.opt      = fdoc_opt_type'({st.floppy_drive_option_config[`FDOC_BIT_OPT_HI],
                                              st.floppy_drive_option_config[`FDOC_BIT_OPT_LO]});
    assign map_bus.rate_sel = rate_select_field_i;

    fdoc_rate_map u_map (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .m      (map_bus.map)
    );

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign rdata_o                    = st.rdata;
    assign xfer_rate_o                = st.xfer_rate;
    assign rate_pin_high_o            = map_bus.pin_out[1];
    assign rate_pin_low_o             = map_bus.pin_out[0];
    assign rate_pin_high_oe_n_o       = map_bus.pin_oe_n;
    assign rate_pin_low_oe_n_o        = map_bus.pin_oe_n;
    assign rate_pins_in_o             = st.pin_sync2;
    assign enhanced_floppy_mode_two_o = st.floppy_drive_option_config[`FDOC_BIT_ENH];
    assign host_mode_o                = fdoc_host_mode_type'({st.floppy_drive_option_config[`FDOC_BIT_FAM],
                                                              st.floppy_drive_option_config[`FDOC_BIT_ENC]});
    assign shared_pin_func_o          = st.floppy_drive_option_config[`FDOC_BIT_SH_HI] ? share_par_irq :
                                        st.floppy_drive_option_config[`FDOC_BIT_SH_LO] ? share_addr_ext :
                                        share_third_drive;
    assign port_extended_setup_o      = st.port_extended_setup;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_select_fdo;
        config_mode_i && sel_wr_i && wdata_i == `FDOC_IDX_FDO;
    endsequence

    sequence s_write_data;
        config_mode_i && data_wr_i && !sel_wr_i;
    endsequence

    property p_fdo_write;
        s_select_fdo ##1 s_write_data
            |=> st.floppy_drive_option_config == {$past(wdata_i[7:1]), 1'b0};
    endproperty
    a_fdo_write: assert property (p_fdo_write) else $error("option register write lost");

    property p_bit0_zero;
        st.floppy_drive_option_config[`FDOC_BIT_RSV] == 1'b0;
    endproperty
    a_bit0_zero: assert property (p_bit0_zero) else $error("reserved bit stored");

    property p_fdo_read;
        config_mode_i && data_rd_i && st.config_selector == `FDOC_IDX_FDO
            |=> rdata_o == $past(st.floppy_drive_option_config) && rdata_o[0] == 1'b0;
    endproperty
    a_fdo_read: assert property (p_fdo_read) else $error("option register read wrong");

    property p_pes_write;
        config_mode_i && data_wr_i && st.config_selector == `FDOC_IDX_PES
            |=> st.port_extended_setup == $past(wdata_i);
    endproperty
    a_pes_write: assert property (p_pes_write) else $error("extended setup write lost");

    property p_locked_out;
        !config_mode_i |=> $stable(st.floppy_drive_option_config) && $stable(st.port_extended_setup)
                           && $stable(st.config_selector);
    endproperty
    a_locked_out: assert property (p_locked_out) else $error("write outside config mode");

    property p_rate_code01;
        rate_select_field_i == 2'h1
            |=> xfer_rate_o == ($past(alt_rate_300_i) ? rate_300 : rate_500);
    endproperty
    a_rate_code01: assert property (p_rate_code01) else $error("code 01 rate wrong");

    property p_host_mode;
        host_mode_o == fdoc_host_mode_type'(st.floppy_drive_option_config[6:5]);
    endproperty
    a_host_mode: assert property (p_host_mode) else $error("host mode decode wrong");

    property p_input_pins;
        rate_pin_high_oe_n_o ##1 (rate_pin_high_oe_n_o && !enhanced_floppy_mode_two_o)
            |-> map_bus.opt == opt_input || $past(map_bus.opt) == opt_input;
    endproperty
    a_input_pins: assert property (p_input_pins) else $error("pins released outside input option");

    sequence s_select_pes;
        config_mode_i && sel_wr_i && wdata_i == `FDOC_IDX_PES;
    endsequence

    sequence s_read_data;
        config_mode_i && data_rd_i && !sel_wr_i;
    endsequence

    property p_sel_write;
        config_mode_i && sel_wr_i |=> st.config_selector == $past(wdata_i);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("selector write lost");

    property p_pes_select_write;
        s_select_pes ##1 s_write_data |=> port_extended_setup_o == $past(wdata_i);
    endproperty
    a_pes_select_write: assert property (p_pes_select_write) else $error("extended setup not reached");

    property p_fdo_select_read;
        s_select_fdo ##1 s_read_data |=> rdata_o == {$past(st.floppy_drive_option_config[7:1]), 1'b0};
    endproperty
    a_fdo_select_read: assert property (p_fdo_select_read) else $error("option register not read");

    property p_pes_read;
        s_select_pes ##1 s_read_data |=> rdata_o == $past(st.port_extended_setup);
    endproperty
    a_pes_read: assert property (p_pes_read) else $error("extended setup not read");

    property p_rd_idle;
        !(config_mode_i && data_rd_i) |=> rdata_o == `FDOC_RD_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

    property p_unmapped_write;
        config_mode_i && data_wr_i && st.config_selector != `FDOC_IDX_FDO && st.config_selector != `FDOC_IDX_PES
            |=> $stable(st.floppy_drive_option_config) && $stable(st.port_extended_setup);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped index written");

    property p_unmapped_read;
        config_mode_i && data_rd_i && st.config_selector != `FDOC_IDX_FDO && st.config_selector != `FDOC_IDX_PES
            |=> rdata_o == `FDOC_RD_IDLE;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped index read");

    property p_rate_1000;
        rate_select_field_i == 2'h3 |=> xfer_rate_o == rate_1000;
    endproperty
    a_rate_1000: assert property (p_rate_1000) else $error("code 11 rate wrong");

    property p_rate_250;
        rate_select_field_i == 2'h2 |=> xfer_rate_o == rate_250;
    endproperty
    a_rate_250: assert property (p_rate_250) else $error("code 10 rate wrong");

    property p_rate_500;
        rate_select_field_i == 2'h0 |=> xfer_rate_o == rate_500;
    endproperty
    a_rate_500: assert property (p_rate_500) else $error("code 00 rate wrong");

    property p_share_irq;
        st.floppy_drive_option_config[`FDOC_BIT_SH_HI] |-> shared_pin_func_o == share_par_irq;
    endproperty
    a_share_irq: assert property (p_share_irq) else $error("shared pin not irq");

    property p_share_addr;
        !st.floppy_drive_option_config[`FDOC_BIT_SH_HI] && st.floppy_drive_option_config[`FDOC_BIT_SH_LO]
            |-> shared_pin_func_o == share_addr_ext;
    endproperty
    a_share_addr: assert property (p_share_addr) else $error("shared pin not address");

    property p_share_drive;
        !st.floppy_drive_option_config[`FDOC_BIT_SH_HI] && !st.floppy_drive_option_config[`FDOC_BIT_SH_LO]
            |-> shared_pin_func_o == share_third_drive;
    endproperty
    a_share_drive: assert property (p_share_drive) else $error("shared pin not drive select");

    property p_pins_sync;
        $past(rstn_i, 2) |-> rate_pins_in_o == $past({rate_pin_high_i, rate_pin_low_i}, 2);
    endproperty
    a_pins_sync: assert property (p_pins_sync) else $error("pin levels not passed on");

    property p_oe_pair;
        rate_pin_high_oe_n_o == rate_pin_low_oe_n_o;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("rate pin enables differ");

    property p_enh_driven;
        enhanced_floppy_mode_two_o |=> !rate_pin_high_oe_n_o && !rate_pin_low_oe_n_o;
    endproperty
    a_enh_driven: assert property (p_enh_driven) else $error("pins released in enhanced mode");

endmodule : fdoc_config

`default_nettype wire

//--- rtl/fdoc_regs.svh
// Purpose: Constants of the floppy option configuration block
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef FDOC_REGS_SVH
`define FDOC_REGS_SVH

// ----------------------------------------------------------------------------
// Selector indexes
// ----------------------------------------------------------------------------
`define FDOC_IDX_FDO    8'h03
`define FDOC_IDX_PES    8'h04

// ----------------------------------------------------------------------------
// Power-up values
// ----------------------------------------------------------------------------
`define FDOC_FDO_RST    8'h78
`define FDOC_PES_RST    8'h00
`define FDOC_SEL_RST    8'h00
`define FDOC_RD_IDLE    8'h00

// ----------------------------------------------------------------------------
// Field positions of the floppy option register
// ----------------------------------------------------------------------------
`define FDOC_BIT_RSV    0
`define FDOC_BIT_ENH    1
`define FDOC_BIT_SH_LO  2
`define FDOC_BIT_OPT_LO 3
`define FDOC_BIT_OPT_HI 4
`define FDOC_BIT_ENC    5
`define FDOC_BIT_FAM    6
`define FDOC_BIT_SH_HI  7

`endif

//--- rtl/fdoc_pkg.sv
// Purpose: Types of the floppy option configuration block
// Assumes: Nothing
// Notes:   Encodings follow the register fields
`default_nettype none

package fdoc_pkg;

    typedef enum logic [1:0] {
        host_legacy  = 2'h0,
        host_alt     = 2'h1,
        host_rsv     = 2'h2,
        host_primary = 2'h3
    } fdoc_host_mode_type;

    typedef enum logic [1:0] {
        share_third_drive = 2'h0,
        share_addr_ext    = 2'h1,
        share_par_irq     = 2'h2
    } fdoc_share_type;

    typedef enum logic [1:0] {
        opt_direct = 2'h0,
        opt_swap   = 2'h1,
        opt_rsv    = 2'h2,
        opt_input  = 2'h3
    } fdoc_opt_type;

    typedef enum logic [2:0] {
        rate_500  = 3'h0,
        rate_300  = 3'h1,
        rate_250  = 3'h2,
        rate_1000 = 3'h3
    } fdoc_rate_type;

endpackage : fdoc_pkg

`default_nettype wire

//--- rtl/fdoc_map_if.sv
// Purpose: Carries option settings to the rate pin mapper and pins back
// Assumes: One clock
// Notes:   Mapper outputs are registered
`default_nettype none

interface fdoc_map_if;
    import fdoc_pkg::*;
    logic         enhanced;
    fdoc_opt_type opt;
    logic [1:0]   rate_sel;
    logic [1:0]   pin_out;
    logic         pin_oe_n;

    modport cfg (output enhanced, opt, rate_sel, input pin_out, pin_oe_n);
    modport map (input enhanced, opt, rate_sel, output pin_out, pin_oe_n);
endinterface : fdoc_map_if

`default_nettype wire

//--- rtl/fdoc_rate_map.sv
// Purpose: Maps the rate select field onto the two rate pins
// Assumes: Settings come from the same clock domain
// Notes:   One cycle from settings to pins
`default_nettype none

module fdoc_rate_map
    import fdoc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    fdoc_map_if.map   m
);

    typedef struct packed {
        logic [1:0] pin_out;
        logic       pin_oe_n;
    } fdoc_map_state_type;

    fdoc_map_state_type st;
    fdoc_map_state_type next_st;
    fdoc_opt_type       eff_opt;

    // ------------------------------------------------------------------------
    // Mapping
    // ------------------------------------------------------------------------
    function automatic logic [1:0] swap_map(input logic [1:0] sel);
        swap_map = {~(sel[1] ^ sel[0]), sel[0]};
    endfunction

    always_comb begin
        next_st  = st;
        eff_opt  = m.enhanced ? opt_direct : m.opt;
        case (eff_opt)
            opt_direct: begin
                next_st.pin_out  = m.rate_sel;
                next_st.pin_oe_n = 1'b0;
            end
            opt_swap: begin
                next_st.pin_out  = swap_map(m.rate_sel);
                next_st.pin_oe_n = 1'b0;
            end
            opt_rsv: begin
                next_st.pin_out  = 2'h0;
                next_st.pin_oe_n = 1'b0;
            end
            default: begin
                next_st.pin_out  = 2'h0;
                next_st.pin_oe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st <= '{pin_out: 2'h0, pin_oe_n: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign m.pin_out  = st.pin_out;
    assign m.pin_oe_n = st.pin_oe_n;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_direct;
        !m.enhanced && m.opt == opt_direct |=> !m.pin_oe_n && m.pin_out == $past(m.rate_sel);
    endproperty
    a_direct: assert property (p_direct) else $error("direct mapping wrong");

    property p_swap;
        !m.enhanced && m.opt == opt_swap
            |=> !m.pin_oe_n && m.pin_out == {~^$past(m.rate_sel), $past(m.rate_sel[0])};
    endproperty
    a_swap: assert property (p_swap) else $error("swapped mapping wrong");

    property p_input;
        !m.enhanced && m.opt == opt_input |=> m.pin_oe_n;
    endproperty
    a_input: assert property (p_input) else $error("pins driven in input option");

    property p_enh_ignore;
        m.enhanced |=> !m.pin_oe_n && m.pin_out == $past(m.rate_sel);
    endproperty
    a_enh_ignore: assert property (p_enh_ignore) else $error("option not ignored");

    property p_rsv_low;
        !m.enhanced && m.opt == opt_rsv |=> !m.pin_oe_n && m.pin_out == 2'h0;
    endproperty
    a_rsv_low: assert property (p_rsv_low) else $error("reserved option not low");

endmodule : fdoc_rate_map

`default_nettype wire

//--- testbench/fdoc_drive_model.sv
// Purpose: Behavioural floppy drive seen through the two rate pins
// Assumes: Pins carry no pull resistor
// Notes:   Drives the pins only when asked and only while the device lets go
`default_nettype none

module fdoc_drive_model (
    input  wire logic       clk_i,
    input  wire logic [1:0] dev_val_i,
    input  wire logic [1:0] dev_oe_n_i,
    input  wire logic       drive_en_i,
    input  wire logic [1:0] drive_val_i,
    output logic      [1:0] lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] churn = 2'h0;

    // --------------------------------------------------------------------
    // Undriven pins wander: low pin every cycle, high pin every second cycle
    // --------------------------------------------------------------------
    always @(posedge clk_i) begin
        churn <= churn + 2'h1;
    end

    // --------------------------------------------------------------------
    // Wire level from both parties
    // --------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (dev_oe_n_i[i] == 1'b0) begin
                lvl_o[i] = dev_val_i[i];
            end else if (drive_en_i) begin
                lvl_o[i] = drive_val_i[i];
            end else begin
                lvl_o[i] = churn[i] ^ i[0];
            end
        end
    end
endmodule // fdoc_drive_model

`default_nettype wire

//--- testbench/fdoc_config_tb.sv
// Purpose: Self-checking bench of the floppy option configuration block
// Assumes: Inputs change on the falling clock edge
// Notes:   Register access through selector and data strobes
`default_nettype none

module fdoc_config_tb;
    import fdoc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0, rstn_i = 1'b0, config_mode_i = 1'b1;
    logic sel_wr_i = 1'b0, data_wr_i = 1'b0, data_rd_i = 1'b0, alt_rate_300_i = 1'b0;
    logic [7:0] wdata_i = 8'h00, rdata_o, port_extended_setup_o, v;
    logic [1:0] rate_select_field_i = 2'h0, rate_pins_in_o, lvl, drive_val = 2'h2;
    logic       drive_en = 1'b1, hi_o, hi_oe_n, lo_o, lo_oe_n, enh_o;
    logic [3:0] e;
    fdoc_rate_type      xfer_rate_o;
    fdoc_host_mode_type host_mode_o;
    fdoc_share_type     shared_pin_func_o;
    int n_errors = 0, comparisons = 0;

    always #25 clk_i = ~clk_i;

    fdoc_config DUT (.clk_i(clk_i), .rstn_i(rstn_i), .config_mode_i(config_mode_i),
        .sel_wr_i(sel_wr_i), .data_wr_i(data_wr_i), .data_rd_i(data_rd_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .rate_select_field_i(rate_select_field_i), .alt_rate_300_i(alt_rate_300_i),
        .xfer_rate_o(xfer_rate_o), .rate_pin_high_o(hi_o), .rate_pin_high_oe_n_o(hi_oe_n),
        .rate_pin_high_i(lvl[1]), .rate_pin_low_o(lo_o), .rate_pin_low_oe_n_o(lo_oe_n),
        .rate_pin_low_i(lvl[0]), .rate_pins_in_o(rate_pins_in_o), .enhanced_floppy_mode_two_o(enh_o),
        .host_mode_o(host_mode_o), .shared_pin_func_o(shared_pin_func_o),
        .port_extended_setup_o(port_extended_setup_o));

    fdoc_drive_model drive (.clk_i(clk_i), .dev_val_i({hi_o, lo_o}), .dev_oe_n_i({hi_oe_n, lo_oe_n}),
        .drive_en_i(drive_en), .drive_val_i(drive_val), .lvl_o(lvl));

    // ------------------------------------------------------------------------
    // Verdict and comparison
    // ------------------------------------------------------------------------
    task automatic close_out();
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------------
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        @(negedge clk_i) sel_wr_i = 1'b1;
        wdata_i = idx;
        @(negedge clk_i) sel_wr_i = 1'b0;
        data_wr_i = 1'b1;
        wdata_i = d;
        @(negedge clk_i) data_wr_i = 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
        @(negedge clk_i) sel_wr_i = 1'b1;
        wdata_i = idx;
        @(negedge clk_i) sel_wr_i = 1'b0;
        data_rd_i = 1'b1;
        @(negedge clk_i) data_rd_i = 1'b0;
        d = rdata_o;
    endtask

    task automatic do_reset();
        rstn_i = 1'b0;
        repeat (4) @(negedge clk_i);
        rstn_i = 1'b1;
    endtask

    // Expected {oe_n high, oe_n low, high, low}
    function automatic logic [3:0] exp_pins(input logic [1:0] opt, input logic enh, input logic [1:0] r);
        if (enh || opt == 2'h0) return {2'b00, r};
        if (opt == 2'h1) return {2'b00, r[1] ~^ r[0], r[0]};
        if (opt == 2'h2) return 4'h0;
        return 4'hC;
    endfunction

    task automatic chk_pins(input logic [1:0] opt, input logic enh, input logic [1:0] r);
        e = exp_pins(opt, enh, r);
        chk({6'h00, hi_oe_n, lo_oe_n}, {6'h00, e[3:2]});
        if (e[3:2] == 2'b00) chk({6'h00, hi_o, lo_o}, {6'h00, e[1:0]});
    endtask

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        do_reset();
        reg_rd(8'h03, v); chk(v, 8'h78);
        reg_rd(8'h04, v); chk(v, 8'h00);
        chk({7'h00, enh_o}, 8'h00);
        chk({6'h00, host_mode_o}, 8'h03);
        chk({6'h00, shared_pin_func_o}, 8'h00);
        repeat (5) @(negedge clk_i);
        chk_pins(2'h3, 1'b0, 2'h0);
        chk({6'h00, rate_pins_in_o}, 8'h02);
        @(negedge clk_i) drive_val = 2'h1;
        repeat (3) @(negedge clk_i);
        chk({6'h00, rate_pins_in_o}, 8'h01);
        reg_wr(8'h03, 8'hFF);
        reg_rd(8'h03, v); chk(v, 8'hFE);
        chk({7'h00, enh_o}, 8'h01);
        chk({6'h00, shared_pin_func_o}, 8'h02);
        reg_wr(8'h03, 8'h1A);
        for (int r = 0; r < 4; r++) begin
            @(negedge clk_i) rate_select_field_i = r[1:0];
            repeat (3) @(negedge clk_i);
            chk_pins(2'h3, 1'b1, r[1:0]);
        end
        for (int opt = 0; opt < 3; opt++) begin
            reg_wr(8'h03, {3'b000, opt[1:0], 3'b000});
            for (int r = 0; r < 4; r++) begin
                @(negedge clk_i) rate_select_field_i = r[1:0];
                repeat (3) @(negedge clk_i);
                chk_pins(opt[1:0], 1'b0, r[1:0]);
            end
        end
        for (int r = 0; r < 8; r++) begin
            @(negedge clk_i) rate_select_field_i = r[1:0];
            alt_rate_300_i = r[2];
            repeat (3) @(negedge clk_i);
            e = (r[1:0] == 2'h3) ? 4'h3 : (r[1:0] == 2'h2) ? 4'h2 : (r[1:0] == 2'h1) ? {3'h0, r[2]} : 4'h0;
            chk({5'h00, xfer_rate_o}, {4'h0, e});
        end
        for (int m = 0; m < 4; m++) begin
            reg_wr(8'h03, {1'b0, m[1:0], 5'h00});
            reg_rd(8'h03, v); chk({6'h00, host_mode_o}, {6'h00, m[1:0]});
        end
        reg_wr(8'h03, 8'h04);
        reg_rd(8'h03, v); chk({6'h00, shared_pin_func_o}, 8'h01);
        reg_wr(8'h03, 8'h80);
        reg_rd(8'h03, v); chk({6'h00, shared_pin_func_o}, 8'h02);
        reg_wr(8'h03, 8'h84);
        reg_rd(8'h03, v); chk({6'h00, shared_pin_func_o}, 8'h02);
        reg_wr(8'h04, 8'hA5);
        reg_rd(8'h04, v); chk(v, 8'hA5);
        chk(port_extended_setup_o, 8'hA5);
        reg_wr(8'h05, 8'h3C);
        reg_rd(8'h05, v); chk(v, 8'h00);
        reg_rd(8'h04, v); chk(v, 8'hA5);
        @(negedge clk_i) config_mode_i = 1'b0;
        reg_wr(8'h03, 8'h22);
        reg_wr(8'h04, 8'h11);
        @(negedge clk_i) config_mode_i = 1'b1;
        reg_rd(8'h03, v); chk(v, 8'h84);
        reg_rd(8'h04, v); chk(v, 8'hA5);
        do_reset();
        reg_rd(8'h03, v); chk(v, 8'h78);
        reg_rd(8'h04, v); chk(v, 8'h00);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        close_out();
    end
endmodule // fdoc_config_tb

`default_nettype wire
